// >>> src/fault_detect_cfg.svh
`ifndef FAULT_DETECT_CFG_SVH
`define FAULT_DETECT_CFG_SVH
// Notes on behaviour
// - mode 0000 accepts a request on a falling edge of the fault pin.
// - modes 0001/0010/0011 sample the pin at clock/8, /16, /128, counting consecutive lows.
// - modes 0100/0101/0110 sample the pin at clock, clock/2, clock/4, counting consecutive lows.
// - a four-bit sample count field picks how many consecutive lows are needed.
// - the input request flag sets when the chosen condition occurs on the fault pin.
// - input request flag clears only by writing 0 after reading it as 1.
// - in sampling modes a clearing write works only while the fault pin is high.
// - conduction flag a covers three complementary pin pairs of the first group.
// - flag a sets when pair 3b/3d, 4a/4c or 4b/4d is both active while enabled.
// - a pair with no output-disable enable never sets a conduction flag.
// - conduction flag a clears only by writing 0 after reading it as 1.
// - a clearing write to a conduction flag needs the group pins at inactive level.
// - conduction flag b sets when pair 6b/6d is both active while enabled.
// - flag b also sets for pairs 7a/7c and 7b/7d when enabled.
// - conduction flag b clears by write 0 after read 1, pins inactive only.

`define ADDR_W 8
`define REG_INPUT_REQ 8'h00
`define REG_SHORT_A 8'h04
`define REG_SHORT_B 8'h08
`define REG_HIZ_EN 8'h0c
`define REG_MODE_EN 8'h10
`define REG_IRQ_STATUS 8'h14
`define REG_IRQ_MASK 8'h18

`define MODE_LO 0
`define MODE_HI 3
`define COUNT_LO 4
`define COUNT_HI 7
`define INPUT_FLAG_BIT 12
`define SHORT_FLAG_BIT 0

`define MODE_EDGE 4'h0
`define MODE_DIV8 4'h1
`define MODE_DIV16 4'h2
`define MODE_DIV128 4'h3
`define MODE_DIV1 4'h4
`define MODE_DIV2 4'h5
`define MODE_DIV4 4'h6

`define DIV_W 7
`define DIV2_MASK 7'h01
`define DIV4_MASK 7'h03
`define DIV8_MASK 7'h07
`define DIV16_MASK 7'h0f
`define DIV128_MASK 7'h7f

`define PAIRS 6
`define PWM_PINS 12
`define GROUP_A_PINS 12'h03f
`define GROUP_B_PINS 12'hfc0
`define GROUP_A_PAIRS 6'h07
`define GROUP_B_PAIRS 6'h38
`define IRQ_W 3
`define IRQ_INPUT 0
`define IRQ_SHORT_A 1
`define IRQ_SHORT_B 2

`define CNT_W 5
`define SAMPLE_MAP_DEFAULT 64'hfedcba9876543210

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> src/fault_detect_pkg.sv
`include "fault_detect_cfg.svh"
package fault_detect_pkg;
    typedef logic [3:0] mode_t;
    typedef logic [`ADDR_W-1:0] addr_t;

    typedef struct packed {
        logic aw_got;
        addr_t awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        mode_t mode;
        logic [3:0] count_sel;
        logic input_flag;
        logic input_armed;
        logic flag_a;
        logic armed_a;
        logic flag_b;
        logic armed_b;
        logic [`PAIRS-1:0] hiz_en;
        logic [`PWM_PINS-1:0] mode_en;
        logic [`IRQ_W-1:0] irq_status;
        logic [`IRQ_W-1:0] irq_mask;
        logic irq;
        logic [`DIV_W-1:0] div_cnt;
        logic pin_prev;
    } top_state_s;

    typedef struct packed {
        logic [`CNT_W-1:0] count;
        logic hit;
    } filter_state_s;
endpackage

// >>> src/pin_sync.sv
`timescale 1ns/1ps
`include "fault_detect_cfg.svh"
module pin_sync
    import fault_detect_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic [`PWM_PINS:0] pins_async,
    output logic [`PWM_PINS:0] pins_sync
);
    typedef struct packed {
        logic [`PWM_PINS:0] first;
        logic [`PWM_PINS:0] second;
    } sync_state_s;

    sync_state_s state;
    sync_state_s next_state;

    // first stage feeds only the second stage
    always_comb begin
        next_state.first = pins_async;
        next_state.second = state.first;
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            state <= '1;
        end else begin
            state <= next_state;
        end
    end

    assign pins_sync = state.second;
endmodule

// >>> src/low_sample_filter.sv
`timescale 1ns/1ps
`include "fault_detect_cfg.svh"
module low_sample_filter
    import fault_detect_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic restart,
    input wire logic sample_en,
    input wire logic pin_low,
    input wire logic [`CNT_W-1:0] target,
    output logic hit
);
    filter_state_s state;
    filter_state_s next_state;

    // count saturates at the target so one low stretch gives a single hit
    always_comb begin
        next_state = state;
        next_state.hit = 1'b0;
        if (restart) begin
            next_state.count = '0;
        end else if (sample_en) begin
            if (!pin_low) begin
                next_state.count = '0;
            end else if (state.count < target) begin
                next_state.count = state.count + `CNT_W'(1);
                next_state.hit = (state.count + `CNT_W'(1)) == target;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign hit = state.hit;
endmodule

// >>> src/output_disable_fault_detect.sv
`timescale 1ns/1ps
`include "fault_detect_cfg.svh"
module output_disable_fault_detect
    import fault_detect_pkg::*;
#(
    parameter logic [63:0] SAMPLE_COUNT_MAP = `SAMPLE_MAP_DEFAULT
)
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic [`ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic fault_request_pin_n,
    input wire logic pwm_pin_3b,
    input wire logic pwm_pin_3d,
    input wire logic pwm_pin_4a,
    input wire logic pwm_pin_4c,
    input wire logic pwm_pin_4b,
    input wire logic pwm_pin_4d,
    input wire logic pwm_pin_6b,
    input wire logic pwm_pin_6d,
    input wire logic pwm_pin_7a,
    input wire logic pwm_pin_7c,
    input wire logic pwm_pin_7b,
    input wire logic pwm_pin_7d,
    output logic irq
);
    top_state_s state;
    top_state_s next_state;

    logic [`PWM_PINS:0] pins_async;
    logic [`PWM_PINS:0] pins_sync;
    logic [`PWM_PINS-1:0] pwm;
    logic fault_pin;
    logic filter_hit;
    logic sample_en;
    logic sampling_mode;
    logic [`CNT_W-1:0] target;
    logic [`PAIRS-1:0] conduct;

    // merges byte lanes of a write into a 16-bit register image
    function automatic logic [15:0] merge16(input logic [15:0] old_value, input logic [31:0] data,
                                            input logic [3:0] strb);
        logic [15:0] result;
        result = old_value;
        if (strb[0]) begin
            result[7:0] = data[7:0];
        end
        if (strb[1]) begin
            result[15:8] = data[15:8];
        end
        return result;
    endfunction

    // true when a write clears a flag bit: lane strobed and bit written as 0
    function automatic logic zero_written(input logic [31:0] data, input logic [3:0] strb, input int bit_pos);
        logic lane;
        lane = strb[bit_pos / 8];
        return lane && !data[bit_pos];
    endfunction

    function automatic logic sample_tick(input mode_t mode, input logic [`DIV_W-1:0] cnt);
        logic tick;
        tick = 1'b0;
        unique case (mode)
            `MODE_DIV8: tick = (cnt & `DIV8_MASK) == `DIV8_MASK;
            `MODE_DIV16: tick = (cnt & `DIV16_MASK) == `DIV16_MASK;
            `MODE_DIV128: tick = (cnt & `DIV128_MASK) == `DIV128_MASK;
            `MODE_DIV1: tick = 1'b1;
            `MODE_DIV2: tick = (cnt & `DIV2_MASK) == `DIV2_MASK;
            `MODE_DIV4: tick = (cnt & `DIV4_MASK) == `DIV4_MASK;
            default: tick = 1'b0;
        endcase
        return tick;
    endfunction

    function automatic logic [31:0] reg_image(input top_state_s s, input addr_t addr);
        logic [31:0] word;
        word = '0;
        unique case (addr)
            `REG_INPUT_REQ: begin
                word[`MODE_HI:`MODE_LO] = s.mode;
                word[`COUNT_HI:`COUNT_LO] = s.count_sel;
                word[`INPUT_FLAG_BIT] = s.input_flag;
            end
            `REG_SHORT_A: word[`SHORT_FLAG_BIT] = s.flag_a;
            `REG_SHORT_B: word[`SHORT_FLAG_BIT] = s.flag_b;
            `REG_HIZ_EN: word[`PAIRS-1:0] = s.hiz_en;
            `REG_MODE_EN: word[`PWM_PINS-1:0] = s.mode_en;
            `REG_IRQ_STATUS: word[`IRQ_W-1:0] = s.irq_status;
            `REG_IRQ_MASK: word[`IRQ_W-1:0] = s.irq_mask;
            default: word = '0;
        endcase
        return word;
    endfunction

    function automatic logic mapped(input addr_t addr);
        return addr == `REG_INPUT_REQ || addr == `REG_SHORT_A || addr == `REG_SHORT_B ||
               addr == `REG_HIZ_EN || addr == `REG_MODE_EN || addr == `REG_IRQ_STATUS ||
               addr == `REG_IRQ_MASK;
    endfunction

    assign pins_async = {fault_request_pin_n, pwm_pin_7d, pwm_pin_7b, pwm_pin_7c, pwm_pin_7a, pwm_pin_6d,
                         pwm_pin_6b, pwm_pin_4d, pwm_pin_4b, pwm_pin_4c, pwm_pin_4a, pwm_pin_3d, pwm_pin_3b};

    pin_sync u_sync (
        .clock(clock),
        .resetn(resetn),
        .pins_async(pins_async),
        .pins_sync(pins_sync)
    );

    assign pwm = pins_sync[`PWM_PINS-1:0];
    assign fault_pin = pins_sync[`PWM_PINS];
    assign sampling_mode = state.mode != `MODE_EDGE;
    assign sample_en = sample_tick(state.mode, state.div_cnt);
    assign target = `CNT_W'(SAMPLE_COUNT_MAP[state.count_sel * 4 +: 4]) + `CNT_W'(1);

    low_sample_filter u_filter (
        .clock(clock),
        .resetn(resetn),
        .restart(!sampling_mode),
        .sample_en(sample_en),
        .pin_low(!fault_pin),
        .target(target),
        .hit(filter_hit)
    );

    // pins are taken as active high; pair p is pins 2p and 2p+1
    always_comb begin
        for (int p = 0; p < `PAIRS; p++) begin
            conduct[p] = pwm[2 * p] && pwm[2 * p + 1] &&
                         (state.hiz_en[p] || state.mode_en[2 * p] || state.mode_en[2 * p + 1]);
        end
    end

    always_comb begin
        logic do_write;
        logic do_read;
        logic input_set;
        logic set_a;
        logic set_b;
        logic [`IRQ_W-1:0] events;
        logic [31:0] read_word;
        logic [15:0] merged;
        do_write = 1'b0;
        do_read = 1'b0;
        input_set = 1'b0;
        set_a = 1'b0;
        set_b = 1'b0;
        events = '0;
        read_word = '0;
        merged = '0;
        next_state = state;

        next_state.div_cnt = state.div_cnt + `DIV_W'(1);
        next_state.pin_prev = fault_pin;

        // address and data are taken in either order
        if (s_axi_awvalid && state.awready) begin
            next_state.aw_got = 1'b1;
            next_state.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && state.wready) begin
            next_state.w_got = 1'b1;
            next_state.wdata = s_axi_wdata;
            next_state.wstrb = s_axi_wstrb;
        end
        if (state.aw_got && state.w_got && !state.bvalid) begin
            do_write = 1'b1;
            next_state.aw_got = 1'b0;
            next_state.w_got = 1'b0;
            next_state.bvalid = 1'b1;
            next_state.bresp = mapped(state.awaddr) ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (state.bvalid && s_axi_bready) begin
            next_state.bvalid = 1'b0;
        end

        if (s_axi_arvalid && state.arready) begin
            do_read = 1'b1;
            read_word = reg_image(state, s_axi_araddr);
            next_state.rvalid = 1'b1;
            next_state.rdata = read_word;
            next_state.rresp = mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (state.rvalid && s_axi_rready) begin
            next_state.rvalid = 1'b0;
        end

        // reading a flag as 1 arms the later clearing write
        if (do_read && s_axi_araddr == `REG_INPUT_REQ && state.input_flag) begin
            next_state.input_armed = 1'b1;
        end
        if (do_read && s_axi_araddr == `REG_SHORT_A && state.flag_a) begin
            next_state.armed_a = 1'b1;
        end
        if (do_read && s_axi_araddr == `REG_SHORT_B && state.flag_b) begin
            next_state.armed_b = 1'b1;
        end

        if (do_write) begin
            unique case (state.awaddr)
                `REG_INPUT_REQ: begin
                    merged = merge16({8'h00, state.count_sel, state.mode}, state.wdata, state.wstrb);
                    next_state.mode = merged[`MODE_HI:`MODE_LO];
                    next_state.count_sel = merged[`COUNT_HI:`COUNT_LO];
                    if (zero_written(state.wdata, state.wstrb, `INPUT_FLAG_BIT) && state.input_armed &&
                        (!sampling_mode || fault_pin)) begin
                        next_state.input_flag = 1'b0;
                        next_state.input_armed = 1'b0;
                    end
                end
                `REG_SHORT_A: begin
                    if (zero_written(state.wdata, state.wstrb, `SHORT_FLAG_BIT) && state.armed_a &&
                        (pwm & `GROUP_A_PINS) == '0) begin
                        next_state.flag_a = 1'b0;
                        next_state.armed_a = 1'b0;
                    end
                end
                `REG_SHORT_B: begin
                    if (zero_written(state.wdata, state.wstrb, `SHORT_FLAG_BIT) && state.armed_b &&
                        (pwm & `GROUP_B_PINS) == '0) begin
                        next_state.flag_b = 1'b0;
                        next_state.armed_b = 1'b0;
                    end
                end
                `REG_HIZ_EN: begin
                    merged = merge16({10'h000, state.hiz_en}, state.wdata, state.wstrb);
                    next_state.hiz_en = merged[`PAIRS-1:0];
                end
                `REG_MODE_EN: begin
                    merged = merge16({4'h0, state.mode_en}, state.wdata, state.wstrb);
                    next_state.mode_en = merged[`PWM_PINS-1:0];
                end
                `REG_IRQ_STATUS: begin
                    if (state.wstrb[0]) begin
                        next_state.irq_status = state.irq_status & ~state.wdata[`IRQ_W-1:0];
                    end
                end
                `REG_IRQ_MASK: begin
                    if (state.wstrb[0]) begin
                        next_state.irq_mask = state.wdata[`IRQ_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // detection is applied after the clears so a same-cycle event wins
        unique case (state.mode)
            `MODE_EDGE: input_set = state.pin_prev && !fault_pin;
            `MODE_DIV8, `MODE_DIV16, `MODE_DIV128, `MODE_DIV1, `MODE_DIV2, `MODE_DIV4: begin
                input_set = filter_hit;
            end
            default: input_set = 1'b0;
        endcase
        set_a = |(conduct & `GROUP_A_PAIRS);
        set_b = |(conduct & `GROUP_B_PAIRS);
        if (input_set) begin
            next_state.input_flag = 1'b1;
        end
        if (set_a) begin
            next_state.flag_a = 1'b1;
        end
        if (set_b) begin
            next_state.flag_b = 1'b1;
        end
        events[`IRQ_INPUT] = input_set && !state.input_flag;
        events[`IRQ_SHORT_A] = set_a && !state.flag_a;
        events[`IRQ_SHORT_B] = set_b && !state.flag_b;
        next_state.irq_status = next_state.irq_status | events;
        next_state.irq = |(next_state.irq_status & next_state.irq_mask);

        // one write and one read in flight; readies drop until the answer is taken
        next_state.awready = !next_state.aw_got && !next_state.bvalid;
        next_state.wready = !next_state.w_got && !next_state.bvalid;
        next_state.arready = !next_state.rvalid;
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            state <= '0;
            state.pin_prev <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    assign s_axi_awready = state.awready;
    assign s_axi_wready = state.wready;
    assign s_axi_bvalid = state.bvalid;
    assign s_axi_bresp = state.bresp;
    assign s_axi_arready = state.arready;
    assign s_axi_rvalid = state.rvalid;
    assign s_axi_rdata = state.rdata;
    assign s_axi_rresp = state.rresp;
    assign irq = state.irq;
endmodule

// >>> verif/fault_pwm_model.sv
`timescale 1ns/1ps
module fault_pwm_model (
    input wire logic clock,
    input wire logic fault_on,
    input wire logic [11:0] pin_on,
    output logic fault_request_pin_n,
    output logic [11:0] pwm_pins
);
    // pins change only just after an edge, like a timer output stage
    always_ff @(posedge clock) begin
        fault_request_pin_n <= !fault_on;
        pwm_pins <= pin_on;
    end
endmodule

// >>> verif/output_disable_fault_detect_asserts.sv
`timescale 1ns/1ps
`include "fault_detect_cfg.svh"
module output_disable_fault_detect_checker
    import fault_detect_pkg::*;
#(
    parameter logic [63:0] SAMPLE_COUNT_MAP = `SAMPLE_MAP_DEFAULT
)
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic irq
);
    logic [`ADDR_W-1:0] rd_addr;
    always_ff @(posedge clock) begin
        if (s_axi_arvalid && s_axi_arready) begin
            rd_addr <= s_axi_araddr;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > `REG_IRQ_MASK
        |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read answered");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper half not zero");
    a_flag_a_alone: assert property (s_axi_rvalid && rd_addr == `REG_SHORT_A |-> s_axi_rdata[31:1] == '0)
        else $error("stray bits beside flag a");
    c_slverr: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == `RESP_SLVERR);
    c_flag_b: cover property (s_axi_rvalid && rd_addr == `REG_SHORT_B && s_axi_rdata[0]);
    c_irq: cover property ($rose(irq));
endmodule
bind output_disable_fault_detect output_disable_fault_detect_checker #(.SAMPLE_COUNT_MAP(SAMPLE_COUNT_MAP))
    checker_i (.*);

// >>> verif/test_output_disable_fault_detect.sv
`timescale 1ns/1ps
`include "fault_detect_cfg.svh"
module test_output_disable_fault_detect;
    import fault_detect_pkg::*;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h0;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    logic irq;
    logic fault_on = 1'b0;
    logic [11:0] pin_on = 12'h000;
    logic fault_n;
    logic [11:0] pwm;
    logic [31:0] cfg;
    logic [7:0] sel;
    int err_count = 0;
    int tests_run = 0;
    int divs [7] = '{1, 8, 16, 128, 1, 2, 4};

    output_disable_fault_detect output_disable_fault_detect_i (
        .clock(clock), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .fault_request_pin_n(fault_n), .pwm_pin_3b(pwm[0]), .pwm_pin_3d(pwm[1]), .pwm_pin_4a(pwm[2]),
        .pwm_pin_4c(pwm[3]), .pwm_pin_4b(pwm[4]), .pwm_pin_4d(pwm[5]), .pwm_pin_6b(pwm[6]),
        .pwm_pin_6d(pwm[7]), .pwm_pin_7a(pwm[8]), .pwm_pin_7c(pwm[9]), .pwm_pin_7b(pwm[10]),
        .pwm_pin_7d(pwm[11]), .irq(irq)
    );
    fault_pwm_model fault_pwm_model_i (
        .clock(clock), .fault_on(fault_on), .pin_on(pin_on), .fault_request_pin_n(fault_n), .pwm_pins(pwm)
    );

    initial begin
        forever #10 clock = ~clock;
    end

    task summarize();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task limit(input int n);
        if (n >= 200) begin
            err_count++;
            $display("MISMATCH %0t bus wait ran out", $time);
            summarize();
        end
    endtask

    task hold(input int n);
        repeat (n) @(posedge clock);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp_r);
        int n;
        logic aw_done;
        logic w_done;
        n = 0;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge clock);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        while (!(aw_done && w_done) && n < 200) begin
            @(posedge clock);
            n++;
            if (awready && !aw_done) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready && !w_done) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (!bvalid && n < 200) begin
            @(posedge clock);
            n++;
        end
        // ready comes late so the response must stand one stalled cycle
        bready <= 1'b1;
        @(posedge clock);
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, exp_r});
        limit(n);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] exp_d, input logic [1:0] exp_r);
        int n;
        n = 0;
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (!arready && n < 200);
        arvalid <= 1'b0;
        while (!rvalid && n < 200) begin
            @(posedge clock);
            n++;
        end
        // ready comes late so the read data must stand one stalled cycle
        rready <= 1'b1;
        @(posedge clock);
        rready <= 1'b0;
        check(rdata, exp_d);
        check({30'h0, rresp}, {30'h0, exp_r});
        limit(n);
    endtask

    initial begin
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd(8'(i * 4), 32'h0, `RESP_OKAY);
        end
        rd(8'h1c, 32'h0, `RESP_SLVERR);
        wr(8'h1c, 32'hffff, `RESP_SLVERR);
        fault_on <= 1'b1;
        hold(2);
        fault_on <= 1'b0;
        hold(6);
        wr(`REG_INPUT_REQ, 32'h0, `RESP_OKAY);
        rd(`REG_INPUT_REQ, 32'h1000, `RESP_OKAY);
        wr(`REG_INPUT_REQ, 32'h0, `RESP_OKAY);
        rd(`REG_INPUT_REQ, 32'h0, `RESP_OKAY);
        // count select 1 asks for two low samples; a low lasting one period spans only one
        for (int m = 1; m < 7; m++) begin
            cfg = 32'h10 | 32'(m);
            wr(`REG_INPUT_REQ, cfg, `RESP_OKAY);
            hold(2 * divs[m] + 4);
            fault_on <= 1'b1;
            hold(divs[m]);
            fault_on <= 1'b0;
            hold(2 * divs[m] + 4);
            rd(`REG_INPUT_REQ, cfg, `RESP_OKAY);
            fault_on <= 1'b1;
            hold(2 * divs[m] + 6);
            rd(`REG_INPUT_REQ, cfg | 32'h1000, `RESP_OKAY);
            wr(`REG_INPUT_REQ, cfg, `RESP_OKAY);
            rd(`REG_INPUT_REQ, cfg | 32'h1000, `RESP_OKAY);
            fault_on <= 1'b0;
            hold(4);
            wr(`REG_INPUT_REQ, cfg, `RESP_OKAY);
            rd(`REG_INPUT_REQ, cfg, `RESP_OKAY);
        end
        for (int p = 0; p < 6; p++) begin
            sel = (p < 3) ? `REG_SHORT_A : `REG_SHORT_B;
            pin_on <= 12'(12'h3 << (2 * p));
            hold(4);
            pin_on <= 12'h000;
            hold(4);
            rd(sel, 32'h0, `RESP_OKAY);
            for (int k = 0; k < 3; k++) begin
                wr(`REG_HIZ_EN, (k == 0) ? 32'(1 << p) : 32'h0, `RESP_OKAY);
                wr(`REG_MODE_EN, (k == 0) ? 32'h0 : 32'(1 << (2 * p + k - 1)), `RESP_OKAY);
                pin_on <= 12'(12'h3 << (2 * p));
                hold(1);
                pin_on <= 12'h000;
                hold(4);
                rd(sel, 32'h1, `RESP_OKAY);
                // one pin alone is no short, but still not the inactive level
                pin_on <= 12'(12'h1 << (2 * p));
                hold(3);
                wr(sel, 32'h0, `RESP_OKAY);
                rd(sel, 32'h1, `RESP_OKAY);
                pin_on <= 12'h000;
                hold(3);
                wr(sel, 32'h0, `RESP_OKAY);
                rd(sel, 32'h0, `RESP_OKAY);
            end
        end
        check({31'h0, irq}, 32'h0);
        rd(`REG_IRQ_STATUS, 32'h7, `RESP_OKAY);
        wr(`REG_IRQ_MASK, 32'h2, `RESP_OKAY);
        hold(3);
        check({31'h0, irq}, 32'h1);
        wr(`REG_IRQ_STATUS, 32'h2, `RESP_OKAY);
        hold(3);
        check({31'h0, irq}, 32'h0);
        rd(`REG_IRQ_STATUS, 32'h5, `RESP_OKAY);
        wr(`REG_IRQ_MASK, 32'h7, `RESP_OKAY);
        hold(3);
        check({31'h0, irq}, 32'h1);
        wr(`REG_IRQ_STATUS, 32'h5, `RESP_OKAY);
        hold(3);
        check({31'h0, irq}, 32'h0);
        rd(`REG_IRQ_MASK, 32'h7, `RESP_OKAY);
        summarize();
    end
endmodule
